// ===== logic/bseq_pkg.sv
// Functional notes
// - Trigger emits N cycles, then holds start level
// - Gated mode: external gate, two cycles minimum
// - Triggered bursts wait delay time before first cycle; gated output starts at once
// - Repeat interval exceeds burst, delay, 0.1us
// - Too-short interval is stretched automatically
// - Cycle count must fit the interval
// - Bursts start and end at start phase
// - Internal source repeats at repeat interval
// - Each manual key press in idle fires one burst; a press during a burst is dropped
// - External source ignores interval, uses input
// - External trigger edge selectable rising/falling
// - Positive gate: 1 runs, 0 stops cleanly
// - Negative gate: 0 runs, 1 stops cleanly
// - Marker output off, rising or falling
// - Sync high during output, low when stopped
// - Sync follows manual or external triggers
package bseq_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on APB
  localparam logic [7:0] ADDR_CTRL      = 8'h00; // Mode, source, edge, polarity, marker
  localparam logic [7:0] ADDR_CYCLES    = 8'h04; // Carrier cycles per burst
  localparam logic [7:0] ADDR_DELAY     = 8'h08; // Delay in clock cycles
  localparam logic [7:0] ADDR_INTERVAL  = 8'h0C; // burst_repeat_interval in clock cycles
  localparam logic [7:0] ADDR_STEP      = 8'h10; // Carrier phase increment per clock
  localparam logic [7:0] ADDR_PHASE     = 8'h14; // Start phase
  localparam logic [7:0] ADDR_CMD       = 8'h18; // Write bit 0: manual_fire_key
  localparam logic [7:0] ADDR_STATUS    = 8'h1C; // State and cycles emitted

  // CTRL field positions
  localparam int CTRL_MODE_BIT  = 0;  // 0 triggered, 1 gated
  localparam int CTRL_SRC_LSB   = 1;  // 2 bits of source
  localparam int CTRL_EDGE_BIT  = 3;  // 0 rising, 1 falling
  localparam int CTRL_POL_BIT   = 4;  // 0 positive, 1 negative
  localparam int CTRL_MARK_LSB  = 5;  // 2 bits of marker_out_select
  localparam int CTRL_EN_BIT    = 7;  // Block enable
  localparam int CMD_FIRE_BIT   = 0;

  // Reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [15:0] CYCLES_RST   = 16'h0001;
  localparam logic [31:0] DELAY_RST    = 32'h0000_0000;
  localparam logic [31:0] INTERVAL_RST = 32'h0000_0400;
  localparam logic [15:0] STEP_RST     = 16'h0400;
  localparam logic [15:0] PHASE_RST    = 16'h0000;

  // Timing: guard gap after each burst
  localparam int CLK_PERIOD_PS = 5000;
  localparam int GUARD_PS      = 100000;
  localparam logic [7:0] GUARD_CYC = 8'((GUARD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] GATE_MIN_CYC = 16'h0002;

  // Trigger sources
  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'b00,
    SRC_MANUAL   = 2'b01,
    SRC_EXTERNAL = 2'b10
  } bseq_src_t;

  // Marker output selection
  typedef enum logic [1:0] {
    MARK_OFF     = 2'b00,
    MARK_RISING  = 2'b01,
    MARK_FALLING = 2'b10
  } bseq_mark_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10,
    ST_GUARD = 2'b11
  } bseq_state_t;

  // Configuration carried as one group
  typedef struct packed {
    logic        enable;
    bseq_mark_t  marker;
    logic        gate_neg;
    logic        edge_fall;
    bseq_src_t   source;
    logic        gated;
    logic [15:0] cycles;
    logic [31:0] delay;
    logic [31:0] interval;
    logic [15:0] step;
    logic [15:0] start_phase;
  } bseq_cfg_t;

endpackage : bseq_pkg

// ===== logic/bseq_top.sv
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
module bseq_top (
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic        EXT_TRIG_IN,
  output logic             TRIG_OUT,
  output logic             SYNC_OUT,
  output logic             BURST_ACTIVE,
  output logic [15:0]      PHASE_OUT
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  // One clock domain throughout; the external level is taken as already
  // synchronous, so a source that is truly asynchronous needs its own
  // synchroniser ahead of this block. Every output is a flop; sync, active and marker
  // are decoded from the next state, so they line up with the state register itself.
  bseq_pkg::bseq_cfg_t   cfg_r;          // Software configuration
  bseq_pkg::bseq_state_t state_r;        // Sequencer state
  bseq_pkg::bseq_state_t state_nxt;      // Next state
  logic [31:0]           cnt_r;          // Delay / guard counter
  logic [31:0]           ivl_r;          // Repeat interval timer
  logic                  ivl_due_r;      // Interval elapsed, start pending
  logic [15:0]           acc_r;          // Carrier phase accumulator
  logic [15:0]           done_r;         // Carrier cycles emitted
  logic                  ext_prev_r;     // Previous external level
  logic                  fire_r;         // Manual key pulse
  logic                  access;         // APB access phase
  logic                  ext_edge;       // Selected edge seen
  logic                  gate_open;      // Gate level active
  logic                  trig;           // Accepted start request
  logic                  wrap;           // Carrier cycle completes this clock
  logic                  last_cycle;     // Stop at this wrap
  logic [16:0]           acc_sum;        // Accumulator with carry

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Small pure functions keep the count rule and the address check in one place;
  // only the error flag uses the check, while the read data has its own case decode.
  // A zero count would never end a burst, so it is treated as one
  function automatic logic [15:0] eff_cycles(input logic [15:0] n);
    eff_cycles = (n == 16'h0000) ? 16'h0001 : n;
  endfunction : eff_cycles

  // Register address check, used only for the error answer
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= bseq_pkg::ADDR_STATUS) && (a[1:0] == 2'b00);
  endfunction : addr_ok

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, then the answer
  // The access is taken on the first access-phase edge; ready rises on that
  // same edge and is sampled on the next one. Masking with ready keeps a held access from being taken twice,
  // which matters for the command word: a double take would fire twice.
  // The price is a fixed extra cycle per transfer, which is cheap here.
  assign access = PSEL && PENABLE && !PREADY;

  // Ready and error flags
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= access;
      PSLVERR <= access && !addr_ok(PADDR);
    end
  end

  // Read data, registered with the answer
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (access && !PWRITE) begin
      case (PADDR)
        bseq_pkg::ADDR_CTRL:     PRDATA <= {24'h00_0000, cfg_r.enable, cfg_r.marker,
                                            cfg_r.gate_neg, cfg_r.edge_fall,
                                            cfg_r.source, cfg_r.gated};
        bseq_pkg::ADDR_CYCLES:   PRDATA <= {16'h0000, cfg_r.cycles};
        bseq_pkg::ADDR_DELAY:    PRDATA <= cfg_r.delay;
        bseq_pkg::ADDR_INTERVAL: PRDATA <= cfg_r.interval;
        bseq_pkg::ADDR_STEP:     PRDATA <= {16'h0000, cfg_r.step};
        bseq_pkg::ADDR_PHASE:    PRDATA <= {16'h0000, cfg_r.start_phase};
        bseq_pkg::ADDR_STATUS:   PRDATA <= {done_r, 14'h0000, state_r};
        default:                 PRDATA <= 32'h0000_0000;
      endcase
    end else if (PREADY) begin
      PRDATA <= 32'h0000_0000;
    end
  end

  // Configuration writes; changes take hold at once, so reprogram while idle
  // There is no shadow copy: a count or step changed mid-burst is used from
  // the next clock on. Shadowing would cost a second set of registers for a
  // case that software can avoid by writing the control word last.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      // Each field from its own slice; the enum fields need a cast
      cfg_r.enable      <= bseq_pkg::CTRL_RST[bseq_pkg::CTRL_EN_BIT];
      cfg_r.marker <= bseq_pkg::bseq_mark_t'(bseq_pkg::CTRL_RST[bseq_pkg::CTRL_MARK_LSB +: 2]);
      cfg_r.gate_neg    <= bseq_pkg::CTRL_RST[bseq_pkg::CTRL_POL_BIT];
      cfg_r.edge_fall   <= bseq_pkg::CTRL_RST[bseq_pkg::CTRL_EDGE_BIT];
      cfg_r.source <= bseq_pkg::bseq_src_t'(bseq_pkg::CTRL_RST[bseq_pkg::CTRL_SRC_LSB +: 2]);
      cfg_r.gated       <= bseq_pkg::CTRL_RST[bseq_pkg::CTRL_MODE_BIT];
      cfg_r.cycles      <= bseq_pkg::CYCLES_RST;
      cfg_r.delay       <= bseq_pkg::DELAY_RST;
      cfg_r.interval    <= bseq_pkg::INTERVAL_RST;
      cfg_r.step        <= bseq_pkg::STEP_RST;
      cfg_r.start_phase <= bseq_pkg::PHASE_RST;
    end else if (access && PWRITE) begin
      case (PADDR)
        bseq_pkg::ADDR_CTRL: begin
          cfg_r.gated     <= PWDATA[bseq_pkg::CTRL_MODE_BIT];
          cfg_r.source    <= bseq_pkg::bseq_src_t'(PWDATA[bseq_pkg::CTRL_SRC_LSB +: 2]);
          cfg_r.edge_fall <= PWDATA[bseq_pkg::CTRL_EDGE_BIT];
          cfg_r.gate_neg  <= PWDATA[bseq_pkg::CTRL_POL_BIT];
          cfg_r.marker    <= bseq_pkg::bseq_mark_t'(PWDATA[bseq_pkg::CTRL_MARK_LSB +: 2]);
          cfg_r.enable    <= PWDATA[bseq_pkg::CTRL_EN_BIT];
        end
        bseq_pkg::ADDR_CYCLES:   cfg_r.cycles      <= PWDATA[15:0];
        bseq_pkg::ADDR_DELAY:    cfg_r.delay       <= PWDATA;
        bseq_pkg::ADDR_INTERVAL: cfg_r.interval    <= PWDATA;
        bseq_pkg::ADDR_STEP:     cfg_r.step        <= PWDATA[15:0];
        bseq_pkg::ADDR_PHASE:    cfg_r.start_phase <= PWDATA[15:0];
        default: begin
          // Unmapped or command: nothing stored here
        end
      endcase
    end
  end

  // Manual key: one pulse per command write
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      fire_r <= 1'b0;
    end else begin
      fire_r <= access && PWRITE && (PADDR == bseq_pkg::ADDR_CMD) &&
                PWDATA[bseq_pkg::CMD_FIRE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Trigger sources
  // Three starters feed one request: the repeat timer, the command pulse
  // and the external pin. In triggered mode only the one that the source field selects is
  // looked at, while gated mode always takes the pin; the others may toggle freely without effect. The edge
  // history resets to the idle low level, so no false edge follows reset.

  // External level history for edge detection
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ext_prev_r <= 1'b0;
    end else begin
      ext_prev_r <= EXT_TRIG_IN;
    end
  end

  // Edge select applies to the external input only
  assign ext_edge  = cfg_r.edge_fall ? (ext_prev_r && !EXT_TRIG_IN)
                                     : (!ext_prev_r && EXT_TRIG_IN);
  // Gate level by polarity
  assign gate_open = cfg_r.gate_neg ? !EXT_TRIG_IN
                                    : EXT_TRIG_IN;

  // Repeat interval timer, start to start
  // The timer restarts on the accepted start, not on the end of the burst,
  // so the interval is measured start to start. If it runs out early, the
  // start waits in a pending flag instead of being dropped.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ivl_r     <= 32'h0000_0000;
      ivl_due_r <= 1'b0;
    end else if (!cfg_r.enable || cfg_r.gated ||
                 cfg_r.source != bseq_pkg::SRC_INTERNAL) begin
      ivl_r     <= 32'h0000_0000;
      ivl_due_r <= 1'b0;
    end else if (trig) begin
      ivl_r     <= 32'h0000_0001;
      ivl_due_r <= 1'b0;
    end else if (ivl_r >= cfg_r.interval - 32'h0000_0001) begin
      // Interval elapsed while the burst or guard still runs: hold the start
      // pending, which stretches the interval to fit the burst
      ivl_due_r <= 1'b1;
    end else begin
      ivl_r <= ivl_r + 32'h0000_0001;
    end
  end

  // Accepted start request; the sequencer only takes it when idle
  always_comb begin
    trig = 1'b0;
    if (cfg_r.enable && state_r == bseq_pkg::ST_IDLE) begin
      if (cfg_r.gated) begin
        trig = gate_open;
      end else begin
        case (cfg_r.source)
          bseq_pkg::SRC_INTERNAL: trig = ivl_due_r;
          bseq_pkg::SRC_MANUAL:   trig = fire_r;
          bseq_pkg::SRC_EXTERNAL: trig = ext_edge;
          default:                trig = 1'b0;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Carrier phase and cycle counting
  // A carrier cycle ends when the accumulator carries out. Stopping right at
  // that carry puts the phase back on zero, so the burst ends where it began.
  // Steps that do not divide the full circle leave a small residue per cycle;
  // the restart at zero discards it rather than letting it drift.
  assign acc_sum = {1'b0, acc_r} + {1'b0, cfg_r.step};
  assign wrap    = (state_r == bseq_pkg::ST_RUN) && acc_sum[16];

  // Triggered: stop at the count; gated: stop after the closing gate, not
  // before two whole cycles
  always_comb begin
    if (cfg_r.gated) begin
      last_cycle = !gate_open &&
                   (done_r + 16'h0001 >= bseq_pkg::GATE_MIN_CYC);
    end else begin
      last_cycle = (done_r + 16'h0001 >= eff_cycles(cfg_r.cycles));
    end
  end

  // Phase accumulator restarts at zero so every burst opens on the start phase
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      acc_r <= 16'h0000;
    end else if (state_r == bseq_pkg::ST_RUN && !(wrap && last_cycle)) begin
      acc_r <= acc_sum[15:0];
    end else begin
      acc_r <= 16'h0000;
    end
  end

  // Cycles emitted in the current burst
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      done_r <= 16'h0000;
    end else if (trig) begin
      done_r <= 16'h0000;
    end else if (wrap) begin
      done_r <= done_r + 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer
  // Idle waits for a request, delay counts the programmed wait, run emits
  // carrier cycles and guard keeps a short gap before the next start.
  // Requests are only looked at in idle, so a manual or external trigger during delay, run or
  // guard is dropped silently rather than queued (the internal timer keeps one pending start); queueing could let a
  // noisy source stack up bursts without limit.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      bseq_pkg::ST_IDLE: begin
        if (trig) begin
          // Gated output starts at once; triggered bursts wait the delay
          state_nxt = (cfg_r.gated || cfg_r.delay == 32'h0000_0000) ?
                      bseq_pkg::ST_RUN : bseq_pkg::ST_DELAY;
        end
      end
      bseq_pkg::ST_DELAY: begin
        if (cnt_r >= cfg_r.delay - 32'h0000_0001) begin
          state_nxt = bseq_pkg::ST_RUN;
        end
      end
      bseq_pkg::ST_RUN: begin
        if (wrap && last_cycle) begin
          state_nxt = bseq_pkg::ST_GUARD;
        end
      end
      bseq_pkg::ST_GUARD: begin
        // Gap after each burst keeps the next start apart
        if (cnt_r >= {24'h00_0000, bseq_pkg::GUARD_CYC} - 32'h0000_0001) begin
          state_nxt = bseq_pkg::ST_IDLE;
        end
      end
      default: state_nxt = bseq_pkg::ST_IDLE;
    endcase
  end

  // State register; disabling aborts to idle at the start level
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_r <= bseq_pkg::ST_IDLE;
    end else if (!cfg_r.enable) begin
      state_r <= bseq_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Delay and guard counter, cleared on every state change
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      cnt_r <= 32'h0000_0000;
    end else if (state_nxt != state_r || !cfg_r.enable) begin
      cnt_r <= 32'h0000_0000;
    end else begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  // Outputs are decoded from the next state so that the registered copy
  // lines up with the state register itself: sync rises on the same edge at
  // which the sequencer enters run. The phase output lags the accumulator by
  // one clock, which is fine because it only has to rest on the start phase.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      BURST_ACTIVE <= 1'b0;
      SYNC_OUT     <= 1'b0;
      TRIG_OUT     <= 1'b0;
      PHASE_OUT    <= 16'h0000;
    end else begin
      BURST_ACTIVE <= (state_nxt == bseq_pkg::ST_RUN) && cfg_r.enable;
      // Sync marks output time, so its timing follows whatever started it
      SYNC_OUT     <= (state_nxt == bseq_pkg::ST_RUN) && cfg_r.enable;
      case (cfg_r.marker)
        bseq_pkg::MARK_RISING:  TRIG_OUT <= (state_nxt == bseq_pkg::ST_RUN) &&
                                            cfg_r.enable;
        bseq_pkg::MARK_FALLING: TRIG_OUT <= !((state_nxt == bseq_pkg::ST_RUN) &&
                                              cfg_r.enable);
        default:                TRIG_OUT <= 1'b0;
      endcase
      // Outside a burst the phase rests on the start phase
      PHASE_OUT    <= cfg_r.start_phase + acc_r;
    end
  end

endmodule : bseq_top

// ===== verif/bseq_top_sva.sv
`timescale 1ns/100ps
module bseq_top_sva (
  input wire logic        CLOCK,
  input wire logic        RESET_N,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR,
  input wire logic        EXT_TRIG_IN,
  input wire logic        TRIG_OUT,
  input wire logic        SYNC_OUT,
  input wire logic        BURST_ACTIVE,
  input wire logic [15:0] PHASE_OUT
);
  default clocking dck @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  //////////////////////////////////////////////////////////////////////////////
  logic        wr_take; // Write accepted at this edge
  logic [7:0]  ctrl_r;  // Shadow of the control word
  logic [15:0] phase_r; // Shadow of the start phase
  logic [7:0]  gap_r;   // Idle cycles before a burst
  assign wr_take = PSEL && PENABLE && PWRITE && !PREADY;
  // Shadows follow only the writes the slave really takes
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      ctrl_r  <= 8'h00;
      phase_r <= 16'h0000;
    end else if (wr_take) begin
      if (PADDR == bseq_pkg::ADDR_CTRL) ctrl_r <= PWDATA[7:0];
      if (PADDR == bseq_pkg::ADDR_PHASE) phase_r <= PWDATA[15:0];
    end
  end
  // Saturates, so a long idle spell never wraps to a small count
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) gap_r <= 8'hFF;
    else if (SYNC_OUT) gap_r <= 8'h00;
    else if (gap_r != 8'hFF) gap_r <= gap_r + 8'h01;
  end
  //////////////////////////////////////////////////////////////////////////////
  marker_rise_a: assert property (
    ctrl_r[6:5] == 2'b01 && $stable(ctrl_r) |-> TRIG_OUT == SYNC_OUT) else $error("marker rise");
  marker_fall_a: assert property (
    ctrl_r[6:5] == 2'b10 && $stable(ctrl_r) |-> TRIG_OUT != SYNC_OUT) else $error("marker fall");
  marker_off_a: assert property (
    ctrl_r[6:5] == 2'b00 && $stable(ctrl_r) |-> !TRIG_OUT) else $error("marker off");
  sync_active_a: assert property (
    SYNC_OUT == BURST_ACTIVE) else $error("sync and active differ");
  guard_gap_a: assert property (
    $rose(SYNC_OUT) |-> gap_r >= bseq_pkg::GUARD_CYC) else $error("guard gap short");
  start_phase_a: assert property (
    $rose(SYNC_OUT) && $stable(phase_r) |-> PHASE_OUT == phase_r) else $error("start phase");
  idle_phase_a: assert property (
    !SYNC_OUT && !$past(SYNC_OUT) && $stable(phase_r) |-> PHASE_OUT == phase_r)
    else $error("idle level");
  ready_wait_a: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  ready_once_a: assert property (
    PREADY |=> !PREADY) else $error("ready held");
  err_map_a: assert property (
    PREADY && (PADDR > 8'h1C || PADDR[1:0] != 2'b00) |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped not refused");
  burst_seen_c: cover property ($rose(SYNC_OUT));
  gated_seen_c: cover property (ctrl_r[0] && $rose(SYNC_OUT));
  error_seen_c: cover property (PREADY && PSLVERR);
endmodule : bseq_top_sva
bind bseq_top bseq_top_sva bseq_top_sva_inst (.CLOCK(CLOCK), .RESET_N(RESET_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY),
  .PRDATA(PRDATA), .PSLVERR(PSLVERR), .EXT_TRIG_IN(EXT_TRIG_IN), .TRIG_OUT(TRIG_OUT),
  .SYNC_OUT(SYNC_OUT), .BURST_ACTIVE(BURST_ACTIVE), .PHASE_OUT(PHASE_OUT));

// ===== verif/bseq_ext_src.sv
`timescale 1ns/100ps
module bseq_ext_src #(
  parameter int MIN_HOLD = 1 // Shortest level the source holds
) (
  input  wire logic clock,
  output logic      ext_level
);
  // Idle low until the bench asks for an edge
  initial ext_level = 1'b0;
  // Level set just after an edge; the caller picks hold so trigger spacing
  // beats burst plus delay, while a gate pulse may be held one clock to test the two-cycle minimum
  task automatic drive(input logic lvl, input int hold);
    int n;
    n = (hold < MIN_HOLD) ? MIN_HOLD : hold;
    @(posedge clock);
    ext_level <= lvl;
    repeat (n) @(posedge clock);
  endtask : drive
endmodule : bseq_ext_src

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        clock = 1'b0;   // 200 MHz
  logic        reset_n = 1'b0; // Synchronous, active low
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        ext_trig;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;  // Stamp, bumped on the falling edge to stay race free
  int          rises = 0;   // Bursts seen
  int          rise_at = 0; // Stamp of the last burst start
  int          gap = 0;     // Start to start of the last two bursts
  int          run = 0;     // Length of the last burst
  logic        sync_d = 1'b0;
  logic        sync_out;
  always #2.5 clock = ~clock;
  bseq_top bseq_top_inst (.CLOCK(clock), .RESET_N(reset_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .EXT_TRIG_IN(ext_trig), .TRIG_OUT(), .SYNC_OUT(sync_out),
    .BURST_ACTIVE(), .PHASE_OUT());
  bseq_ext_src bseq_ext_src_inst (.clock(clock), .ext_level(ext_trig));
  //////////////////////////////////////////////////////////////////////////////
  // Cycle stamp and hang guard
  always @(negedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      close_out();
    end
  end
  // Burst monitor: count, start stamp, period and width
  always @(posedge clock) begin
    if (sync_out === 1'b1 && sync_d !== 1'b1) begin
      rises++;
      gap = cycles - rise_at;
      rise_at = cycles;
      run = 0;
    end
    if (sync_out === 1'b1) run++;
    sync_d = sync_out;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out
  // One APB transfer; request held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 40);
    // A transfer that never completes counts against the run
    if (pready !== 1'b1) errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'b1, d, q, e);
  endtask : wr
  // Three cycles at two clocks each; control word last so it starts clean
  task automatic cfg(input logic [7:0] c, input logic [31:0] dly);
    wr(bseq_pkg::ADDR_CYCLES, 32'h3);
    wr(bseq_pkg::ADDR_DELAY, dly);
    wr(bseq_pkg::ADDR_INTERVAL, 32'h64);
    wr(bseq_pkg::ADDR_STEP, 32'h8000);
    wr(bseq_pkg::ADDR_CTRL, {24'h0, c});
  endtask : cfg
  //////////////////////////////////////////////////////////////////////////////
  // Reset values, a read-only write and an unmapped read
  task automatic sc_regs;
    logic [31:0] q;
    logic        e;
    logic [31:0] exp [9];
    exp = '{32'h0, 32'h1, 32'h0, 32'h400, 32'h400, 32'h0, 32'h0, 32'h0, 32'h0};
    wr(8'h1C, 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++) begin
      xfer(8'(i * 4), 1'b0, 32'h0, q, e);
      check(q, exp[i]);
      check({31'h0, e}, 32'(i == 8));
    end
  endtask : sc_regs
  // Key press, optionally pressed again while the burst is pending
  task automatic press(input logic twice, output int lat, output int cnt);
    cnt = rises;
    wr(bseq_pkg::ADDR_CMD, 32'h1);
    lat = cycles;
    if (twice) wr(bseq_pkg::ADDR_CMD, 32'h1);
    repeat (60) @(posedge clock);
    lat = rise_at - lat;
    cnt = rises - cnt;
  endtask : press
  task automatic sc_manual;
    int l0;
    int l1;
    int n;
    wr(bseq_pkg::ADDR_PHASE, 32'h1234);
    cfg(8'hA2, 32'h0);
    press(1'b0, l0, n);
    check(32'(run), 32'h6);
    check(32'(n), 32'h1);
    wr(bseq_pkg::ADDR_DELAY, 32'h14);
    press(1'b1, l1, n);
    check(32'(n), 32'h1);
    check(32'(l1 - l0), 32'h14);
  endtask : sc_manual
  task automatic sc_internal;
    cfg(8'hC0, 32'h0);
    repeat (250) @(posedge clock);
    check(32'(gap), 32'h64);
    wr(bseq_pkg::ADDR_INTERVAL, 32'hA);
    repeat (100) @(posedge clock);
    check(32'(gap >= 6 + bseq_pkg::GUARD_CYC), 32'h1);
    wr(bseq_pkg::ADDR_CTRL, 32'h82);
    repeat (60) @(posedge clock);
  endtask : sc_internal
  task automatic sc_external;
    int n;
    for (int e = 0; e < 2; e++) begin
      cfg(e ? 8'h8C : 8'h84, 32'h0);
      n = rises;
      repeat (300) @(posedge clock);
      check(32'(rises - n), 32'h0);
      bseq_ext_src_inst.drive(1'b1, 60);
      check(32'(rises - n), 32'(1 - e));
      bseq_ext_src_inst.drive(1'b0, 60);
      check(32'(rises - n), 32'h1);
    end
  endtask : sc_external
  task automatic sc_gated;
    int n;
    for (int p = 0; p < 2; p++) begin
      cfg(p ? 8'h95 : 8'h85, 32'h0);
      bseq_ext_src_inst.drive(p[0], 40);
      n = rises;
      bseq_ext_src_inst.drive(p[0], 40);
      check(32'(rises - n), 32'h0);
      bseq_ext_src_inst.drive(!p[0], 1);
      bseq_ext_src_inst.drive(p[0], 40);
      check(32'(rises - n), 32'h1);
      check(32'(run), 32'h4);
      bseq_ext_src_inst.drive(!p[0], 9);
      bseq_ext_src_inst.drive(p[0], 40);
      check(32'(run >= 8 && run[0] == 1'b0), 32'h1);
    end
  endtask : sc_gated
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    sc_regs();
    sc_manual();
    sc_internal();
    sc_external();
    sc_gated();
    close_out();
  end
endmodule : tb_top
